// File: src/mpc_compare.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "mpc_map.svh"

// Contract
// R1: up to 32 preset targets per channel
// R2: single mode uses single preset, updated on flag
// R3: multi mode ignores single preset and flag
// R4: table-load bit picks reload or keep presets
// R5: software puts table at odd base address
// R6: count byte at 0, targets from offset 1
// R7: relative entry magnitude <=1 ends the list
// R8: absolute step <=1 from previous ends list
// R9: next target armed only after current matches
// R10: software picks target sign by count direction
// R11: absolute targets match count value directly
// R12: relative targets accumulate from start reference
// R13: cyclic only acts in relative mode
// R14: non-cyclic stops after last, software restarts
// R15: cyclic rebases on count and restarts forever
// R16: each target raises its own event number
// R17: auto-start strap starts counting after reset
// R18: software configures then issues start command
// R19: cyclic selected by its own control bit
// R20: active segment index readable from zero
// R21: faulty table sets a status flag
// R22: 32-bit signed compare, one event per pass
module mpc_compare
	import mpc_pkg::*;
#(
	parameter logic [1:0] CHAN = 2'h0
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire mpc_apb_req_t apb,
	output mpc_apb_rsp_t apb_rsp,
	input wire logic pulse_up,
	input wire logic pulse_dn,
	input wire logic auto_start,
	output logic count_match_event,
	output logic [7:0] match_number,
	output logic [7:0] active_segment_index
);

	mpc_state_t st_q;
	logic [5:0] ctrl_q;
	logic [2:0] mode_q;
	logic signed [31:0] count_q, spre_q, single_q, tgt_q, prev_q, ref_q, acc_q;
	logic [15:0] base_q;
	logic [7:0] mem_q [256];
	logic signed [31:0] pv_q [32];
	logic [7:0] ptr_q;
	logic [5:0] k_q, n_q;
	logic [4:0] idx_q;
	logic [1:0] nb_q, boot_q;
	logic [2:0] up_s, dn_s;
	logic [1:0] as_s;
	logic eq_q, fault_q;
	logic wr, start, fault_clr, fault_set, hit, last, term, bad_qty, eq_s, rd_hit;
	logic [7:0] tbyte, evt_base;
	logic signed [31:0] entry, nxt;
	logic [31:0] rd_d;

	function automatic logic near1(input logic signed [32:0] d);
		return (d >= -33'sh1) && (d <= 33'sh1);
	endfunction

	assign evt_base = `MPC_EVT_BASE + {1'b0, CHAN, 5'h00};
	assign wr = ce && apb.psel && apb.penable && apb_rsp.pready && apb.pwrite;
	assign fault_clr = wr && apb.paddr == `MPC_STAT && apb.pwdata[`MPC_B_FAULT];
	// auto-start fires once, after the strap has crossed both sync stages
	assign start = (wr && apb.paddr == `MPC_CTRL && apb.pwdata[`MPC_B_START]) // R18
		|| (ce && boot_q == `MPC_BOOT_WAIT - 2'h1 && as_s[1]); // R17
	// table wraps inside the 256-byte window; upper base bits ignored
	assign tbyte = mem_q[8'(base_q[7:0] + ptr_q)]; // R5 R6
	assign entry = {acc_q[23:0], tbyte};
	assign bad_qty = tbyte == 8'h00 || tbyte > `MPC_MAX_PV; // R1
	assign term = mode_q[`MPC_B_REL] ? near1(33'(entry)) // R7
		: (k_q != 6'h00 && near1(33'(entry) - 33'(prev_q))); // R8
	assign hit = count_q == tgt_q; // R22
	assign last = {1'b0, idx_q} == n_q - 6'h01;
	assign nxt = mode_q[`MPC_B_REL] ? tgt_q + pv_q[5'(idx_q + 5'h01)] // R12
		: pv_q[5'(idx_q + 5'h01)]; // R11
	assign eq_s = count_q == single_q;
	assign fault_set = !start && ((st_q == MPC_LOAD && ptr_q == 8'h00 && bad_qty)
		|| (st_q == MPC_LOAD && ptr_q != 8'h00 && nb_q == `MPC_LAST_BYTE && term
		&& k_q == 6'h00) || (st_q == MPC_ARM && n_q == 6'h00)); // R21

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			up_s <= '0;
			dn_s <= '0;
			as_s <= '0;
			boot_q <= '0;
		end
		else if (ce)
		begin
			up_s <= {up_s[1:0], pulse_up};
			dn_s <= {dn_s[1:0], pulse_dn};
			as_s <= {as_s[0], auto_start};
			if (boot_q != `MPC_BOOT_WAIT)
				boot_q <= boot_q + 2'h1;
		end
	end

	// counts only once started; a load write overrides a pulse in that cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			count_q <= '0;
		else if (ce)
		begin
			if (wr && apb.paddr == `MPC_COUNT)
				count_q <= apb.pwdata;
			else if (st_q != MPC_IDLE && up_s[2:1] == 2'b01 && dn_s[2:1] != 2'b01)
				count_q <= count_q + 32'sh1;
			else if (st_q != MPC_IDLE && dn_s[2:1] == 2'b01 && up_s[2:1] != 2'b01)
				count_q <= count_q - 32'sh1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_q <= '0;
			spre_q <= '0;
			base_q <= '0;
		end
		else if (wr)
		begin
			if (apb.paddr == `MPC_CTRL)
				ctrl_q <= apb.pwdata[5:0];
			if (apb.paddr == `MPC_SPRE)
				spre_q <= apb.pwdata;
			if (apb.paddr == `MPC_BASE)
				base_q <= apb.pwdata[15:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (wr && apb.paddr[11:10] == `MPC_MEM_SEL)
			mem_q[apb.paddr[9:2]] <= apb.pwdata[7:0];
	end

	always_comb
	begin
		rd_hit = 1'b1;
		rd_d = '0;
		if (apb.paddr[11:10] == `MPC_MEM_SEL)
			rd_d = {24'h000000, mem_q[apb.paddr[9:2]]};
		else
			unique case (apb.paddr)
				`MPC_CTRL: rd_d = {26'h0000000, ctrl_q};
				`MPC_COUNT: rd_d = count_q;
				`MPC_SPRE: rd_d = spre_q;
				`MPC_BASE: rd_d = {16'h0000, base_q};
				`MPC_STAT: rd_d = {22'h000000, st_q != MPC_IDLE, fault_q, 3'h0, idx_q}; // R20
				`MPC_EVT: rd_d = {24'h000000, match_number};
				default: rd_hit = 1'b0;
			endcase
	end

	// read data is sampled in the setup cycle; answer comes one cycle later
	always_ff @(posedge clock)
	begin
		if (rst)
			apb_rsp <= '0;
		else if (ce)
		begin
			apb_rsp.pready <= apb.psel && !apb.penable;
			if (apb.psel && !apb.penable)
			begin
				apb_rsp.prdata <= rd_d;
				apb_rsp.pslverr <= !rd_hit;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_q <= MPC_IDLE;
			mode_q <= '0;
			ptr_q <= '0;
			acc_q <= '0;
			nb_q <= '0;
			k_q <= '0;
			n_q <= '0;
			idx_q <= '0;
			tgt_q <= '0;
			prev_q <= '0;
			ref_q <= '0;
			single_q <= '0;
			eq_q <= 1'b0;
			fault_q <= 1'b0;
			count_match_event <= 1'b0;
			match_number <= '0;
		end
		else if (ce)
		begin
			count_match_event <= 1'b0;
			eq_q <= eq_s;
			// a new fault wins over a clear in the same cycle
			fault_q <= fault_set || (fault_q && !fault_clr); // R21
			if (start)
			begin
				mode_q <= ctrl_q[2:0];
				ref_q <= count_q;
				idx_q <= '0;
				ptr_q <= '0;
				nb_q <= '0;
				k_q <= '0;
				if (!ctrl_q[`MPC_B_MULTI])
				begin
					if (ctrl_q[`MPC_B_UPD])
						single_q <= spre_q; // R2
					st_q <= MPC_RUN;
				end
				else if (ctrl_q[`MPC_B_LOAD])
					st_q <= MPC_LOAD; // R3 R4
				else
					st_q <= MPC_ARM; // R4
			end
			else
				unique case (st_q)
					MPC_LOAD:
					begin
						ptr_q <= ptr_q + 8'h01;
						if (ptr_q == 8'h00)
						begin
							if (bad_qty)
								st_q <= MPC_IDLE;
						end
						else
						begin
							acc_q <= entry;
							nb_q <= nb_q + 2'h1;
							if (nb_q == `MPC_LAST_BYTE)
							begin
								if (term)
								begin
									n_q <= k_q; // R7 R8
									st_q <= k_q == 6'h00 ? MPC_IDLE : MPC_ARM;
								end
								else
								begin
									pv_q[k_q[4:0]] <= entry;
									prev_q <= entry;
									k_q <= k_q + 6'h01;
									if (k_q + 6'h01 == 6'(mem_q[base_q[7:0]]))
									begin
										n_q <= k_q + 6'h01;
										st_q <= MPC_ARM;
									end
								end
							end
						end
					end
					MPC_ARM:
					begin
						idx_q <= '0;
						tgt_q <= mode_q[`MPC_B_REL] ? ref_q + pv_q[0] : pv_q[0]; // R12
						st_q <= n_q == 6'h00 ? MPC_IDLE : MPC_RUN;
					end
					MPC_RUN:
					begin
						if (!mode_q[`MPC_B_MULTI])
						begin
							if (eq_s && !eq_q)
							begin
								count_match_event <= 1'b1;
								match_number <= `MPC_SINGLE_EVT;
							end
						end
						else if (hit)
						begin
							count_match_event <= 1'b1;
							match_number <= evt_base + {3'h0, idx_q}; // R16
							if (last)
							begin
								if (mode_q[`MPC_B_REL] && mode_q[`MPC_B_CYC]) // R13 R19
								begin
									idx_q <= '0;
									tgt_q <= count_q + pv_q[0]; // R15
								end
								else
									st_q <= MPC_DONE; // R14
							end
							else
							begin
								idx_q <= idx_q + 5'h01; // R9
								tgt_q <= nxt;
							end
						end
					end
					MPC_IDLE, MPC_DONE:
					begin
					end
					default: st_q <= MPC_IDLE;
				endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			active_segment_index <= '0;
		else if (ce)
			active_segment_index <= {3'h0, idx_q}; // R20
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic mhit;
	assign mhit = ce && !start && st_q == MPC_RUN && mode_q[`MPC_B_MULTI] && hit;

	event_number_a: assert property (mhit |=> count_match_event // R16
		&& match_number == evt_base + {3'h0, $past(idx_q)})
		else $error("wrong match event number");
	seq_advance_a: assert property (mhit && !last |=> idx_q == $past(idx_q) + 5'h01) // R9
		else $error("segment did not advance");
	list_bound_a: assert property (n_q <= 6'(`MPC_MAX_PV)) // R1
		else $error("target count above limit");
	rel_next_a: assert property (mhit && !last && mode_q[`MPC_B_REL] // R12
		|=> tgt_q == $past(tgt_q) + pv_q[idx_q])
		else $error("relative target not accumulated");
	abs_next_a: assert property (mhit && !last && !mode_q[`MPC_B_REL] // R11
		|=> tgt_q == pv_q[idx_q])
		else $error("absolute target not taken");
	stop_last_a: assert property (mhit && last // R14
		&& !(mode_q[`MPC_B_REL] && mode_q[`MPC_B_CYC]) |=> st_q == MPC_DONE)
		else $error("sequence did not stop");
	cyclic_rebase_a: assert property (mhit && last && mode_q[`MPC_B_REL] // R15
		&& mode_q[`MPC_B_CYC] |=> st_q == MPC_RUN && idx_q == 5'h00
		&& tgt_q == $past(count_q) + pv_q[0])
		else $error("cyclic rebase failed");
	single_event_a: assert property (st_q == MPC_RUN && !mode_q[`MPC_B_MULTI] // R2
		&& count_match_event |-> match_number == `MPC_SINGLE_EVT)
		else $error("single mode event number wrong");
	keep_table_a: assert property (start && ctrl_q[`MPC_B_MULTI] // R4
		&& !ctrl_q[`MPC_B_LOAD] |=> st_q == MPC_ARM ##1 st_q != MPC_LOAD)
		else $error("table reloaded when it should be kept");
	fault_flag_a: assert property (ce && fault_set |=> fault_q [*2]) // R21
		else $error("fault flag not held");
	once_pass_a: assert property (count_match_event && mode_q[`MPC_B_MULTI] // R22
		&& st_q == MPC_RUN && !$stable(idx_q) |-> !$past(count_match_event)
		|| match_number != $past(match_number))
		else $error("target raised twice");

	wrap_c: cover property (mhit && last && mode_q[`MPC_B_CYC]);
	done_c: cover property (st_q == MPC_RUN ##1 st_q == MPC_DONE);
	fault_c: cover property ($rose(fault_q));
	single_c: cover property (count_match_event && !mode_q[`MPC_B_MULTI]);

endmodule

// File: src/mpc_map.svh
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// register byte offsets
`define MPC_CTRL 12'h000
`define MPC_COUNT 12'h004
`define MPC_SPRE 12'h008
`define MPC_BASE 12'h00C
`define MPC_STAT 12'h010
`define MPC_EVT 12'h014
// byte memory window select, paddr[11:10]
`define MPC_MEM_SEL 2'h1

// control bits
`define MPC_B_MULTI 0
`define MPC_B_REL 1
`define MPC_B_CYC 2
`define MPC_B_LOAD 4
`define MPC_B_UPD 5
`define MPC_B_START 8
// status bits, index in [4:0]
`define MPC_B_FAULT 8
`define MPC_B_RUN 9

`define MPC_MAX_PV 8'h20
`define MPC_EVT_BASE 8'h40
`define MPC_SINGLE_EVT 8'h0C
`define MPC_LAST_BYTE 2'h3
`define MPC_BOOT_WAIT 2'h3

`endif

// File: src/mpc_pkg.sv
package mpc_pkg;

	typedef enum logic [2:0] {
		MPC_IDLE = 3'h0,
		MPC_LOAD = 3'h1,
		MPC_ARM = 3'h3,
		MPC_RUN = 3'h2,
		MPC_DONE = 3'h6
	} mpc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mpc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mpc_apb_rsp_t;

endpackage

// File: sim/mpc_pulse_src.sv
`timescale 1ns/100ps

// behavioural pulse source on the count pins, paced by gap
module mpc_pulse_src (
	input wire logic clock,
	input wire logic go,
	input wire logic down,
	input wire logic [7:0] number,
	input wire logic [1:0] gap,
	output logic pulse_up,
	output logic pulse_dn,
	output logic busy
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] tick_q = 3'h0;
	logic level_q = 1'b0;

	// high and low each last at least two cycles so the 2-FF sync never misses one
	always_ff @(posedge clock)
	begin
		if (go)
		begin
			left_q <= number;
			tick_q <= 3'h0;
		end
		else if (left_q != 8'h00)
		begin
			tick_q <= tick_q + 3'h1;
			if (tick_q == {1'b0, gap} + 3'h2)
			begin
				tick_q <= 3'h0;
				level_q <= !level_q;
				if (level_q)
					left_q <= left_q - 8'h01;
			end
		end
	end

	assign pulse_up = level_q & !down;
	assign pulse_dn = level_q & down;
	assign busy = left_q != 8'h00;
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
`include "mpc_map.svh"

module testbench import mpc_pkg::*;;
	localparam logic [1:0] CHAN = 2'h1;
	localparam logic [7:0] TB = 8'h01;
	localparam logic [31:0] MUL = 32'h1 << `MPC_B_MULTI;
	localparam logic [31:0] REL = 32'h1 << `MPC_B_REL;
	localparam logic [31:0] CYC = 32'h1 << `MPC_B_CYC;
	localparam logic [31:0] LD = 32'h1 << `MPC_B_LOAD;
	localparam logic [31:0] UPD = 32'h1 << `MPC_B_UPD;
	localparam logic [31:0] GO = 32'h1 << `MPC_B_START;
	logic clock, rst, ce, auto_start, go, down, pulse_up, pulse_dn, busy, evt, err;
	logic [7:0] number, seg, num;
	logic [1:0] gap;
	logic [31:0] rd, start_cnt;
	mpc_apb_req_t req;
	mpc_apb_rsp_t rsp;
	int errors, tests_run, seed;
	logic [7:0] evq[$], expq[$];

	mpc_compare #(.CHAN(CHAN)) mpc_compare_inst (.clock(clock), .rst(rst), .ce(ce), .apb(req),
		.apb_rsp(rsp), .pulse_up(pulse_up), .pulse_dn(pulse_dn), .auto_start(auto_start),
		.count_match_event(evt), .match_number(num), .active_segment_index(seg));
	mpc_pulse_src mpc_pulse_src_inst (.clock(clock), .go(go), .down(down), .number(number),
		.gap(gap), .pulse_up(pulse_up), .pulse_dn(pulse_dn), .busy(busy));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = !clock;
	end

	always @(posedge clock)
		if (evt === 1'b1)
			evq.push_back(num);

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20)
			errors++;
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge clock);
	endtask

	task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask

	// count byte first, then each target most significant byte first
	task automatic put_table(input logic [7:0] cnt, input logic [31:0] e[4]);
		logic [7:0] b;
		for (int i = 0; i < 17; i++)
		begin
			b = (i == 0) ? cnt : 8'(e[(i - 1) / 4] >> (8 * (3 - (i - 1) % 4)));
			apb(1'b1, 12'h400 + 12'(4 * (TB + i)), {24'h0, b});
		end
		apb(1'b1, `MPC_BASE, {24'h0, TB});
	endtask

	task automatic run(input logic [31:0] ctrl, input logic [31:0] cnt);
		apb(1'b1, `MPC_COUNT, cnt);
		apb(1'b1, `MPC_CTRL, ctrl);
		apb(1'b1, `MPC_CTRL, ctrl | GO);
		repeat (30) @(posedge clock);
	endtask

	task automatic pulses(input logic [7:0] n, input logic dn);
		int k;
		go <= 1'b1;
		number <= n;
		down <= dn;
		gap <= 2'($random(seed));
		@(posedge clock);
		go <= 1'b0;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (busy && k < 500);
		repeat (8) @(posedge clock);
	endtask

	task automatic chk_evts();
		check("event count", expq.size(), evq.size());
		foreach (expq[i])
			if (i < evq.size())
				check("event number", {24'h0, expq[i]}, {24'h0, evq[i]});
		evq.delete();
		expq.delete();
	endtask

	function automatic logic [7:0] evt_no(input int idx);
		return `MPC_EVT_BASE + 8'(CHAN) * 8'h20 + 8'(idx);
	endfunction

	task automatic finish_test();
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		seed = 32'h450BA441;
		{rst, ce, auto_start, go, down, number, gap, req} <= {3'b111, 12'h000, 47'h0};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		rchk("auto start", `MPC_STAT, 32'h200);
		rst <= 1'b1;
		auto_start <= 1'b0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		evq.delete();
		rchk("ctrl reset", `MPC_CTRL, 32'h0);
		rchk("stat reset", `MPC_STAT, 32'h0);
		rchk("unmapped", 12'h020, 32'h0);
		check("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, `MPC_SPRE, 32'h3);
		run(UPD, 32'h0);
		pulses(8'h4, 1'b0);
		expq.push_back(`MPC_SINGLE_EVT);
		chk_evts();
		put_table(8'h4, '{32'h2, 32'h4, 32'h6, 32'h7});
		for (int p = 0; p < 2; p++)
		begin
			run(p == 0 ? MUL | CYC | LD : MUL, 32'h0);
			pulses(8'h9, 1'b0);
			for (int i = 0; i < 3; i++)
				expq.push_back(evt_no(i));
			chk_evts();
			put_table(8'h2, '{32'h14, 32'h28, 32'h0, 32'h0});
		end
		put_table(8'h5, '{32'h2, 32'h3, 32'h0, 32'h9});
		start_cnt = $random(seed);
		run(MUL | REL | CYC | LD, start_cnt);
		pulses(8'h2, 1'b0);
		check("segment", 32'h1, {24'h0, seg});
		pulses(8'h8, 1'b0);
		for (int i = 0; i < 4; i++)
			expq.push_back(evt_no(i % 2));
		chk_evts();
		rchk("count", `MPC_COUNT, start_cnt + 32'hA);
		put_table(8'h2, '{-32'sd2, -32'sd3, 32'h0, 32'h0});
		run(MUL | REL | LD, 32'h0);
		pulses(8'h5, 1'b1);
		pulses(8'h6, 1'b1);
		expq = '{evt_no(0), evt_no(1)};
		chk_evts();
		put_table(8'h0, '{32'h2, 32'h4, 32'h6, 32'h7});
		run(MUL | LD, 32'h0);
		rchk("fault", `MPC_STAT, 32'h100);
		apb(1'b1, `MPC_STAT, 32'h100);
		rchk("fault clear", `MPC_STAT, 32'h0);
		finish_test();
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		errors++;
		finish_test();
	end
endmodule
